// ---- shared/hbsc_regs.svh ----
// offsets, field positions, reset values and timing of the half-bridge control block
`ifndef HBSC_REGS_SVH
`define HBSC_REGS_SVH
`define HBSC_OFS_CTRL   8'h00
`define HBSC_OFS_CMD    8'h04
`define HBSC_OFS_STAT   8'h08
`define HBSC_OFS_CODE   8'h0C
`define HBSC_CMD_SRST   0
`define HBSC_CMD_CFG    1
`define HBSC_CMD_EN     7
`define HBSC_CMD_ULOFF  13
`define HBSC_CMD_GRP    14
`define HBSC_CMD_OVLK   15
`define HBSC_ST_OVC     15
`define HBSC_ST_SUPF    14
`define HBSC_ST_UNDL    13
`define HBSC_ST_WARN    0
`define HBSC_GRP0_N     6
`define HBSC_PULSE_N    2
`define HBSC_CODE_OFF   2'h0
`define HBSC_CODE_OVC   2'h1
`define HBSC_CODE_UNDL  2'h2
`define HBSC_CODE_ON    2'h3
`define HBSC_RST_CMD    16'h0000
`define HBSC_FRAME_MIN  5'h10
`define HBSC_FRAME_WRAP 5'h17
`define HBSC_CLK_NS     50
`define HBSC_DEAD_NS    500
`define HBSC_OCD_NS     10000
`define HBSC_CYC_UP(ns) (((ns) + `HBSC_CLK_NS - 1) / `HBSC_CLK_NS)
`endif

// ---- shared/hbsc_pkg.sv ----
// types of the half-bridge serial control block
`default_nettype none
package hbsc_pkg;
  // pins from outside the clock domain
  typedef struct packed {
    logic       sel;
    logic       sclk;
    logic       sdi;
    logic       en;
    logic       uv;
    logic       ov;
    logic       hot;
    logic       warn;
    logic [1:0] pulse;
    logic [7:0] oc;
    logic [7:0] ul;
  } hbsc_pins_t;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] cfg;
  } hbsc_cmd_t;

  typedef struct packed {
    hbsc_pins_t  s1;
    hbsc_pins_t  s2;
    logic        sclkD;
    logic        selD;
    logic        live;
    logic [4:0]  bitCnt;
    logic        started;
    logic [15:0] inReg;
    logic [15:0] outReg;
    logic [15:0] snap;
    logic        snapHold;
    logic [15:0] cmdWord;
    hbsc_cmd_t   cmd;
    logic        thermal;
    logic [7:0]  ovc;
    logic [7:0]  undl;
    logic        frameErr;
    logic        serialOut;
    logic        serialOutEn;
    logic [7:0]  dead;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } hbsc_state_t;

  typedef struct packed {
    logic       hs;
    logic       ls;
    logic [7:0] cnt;
  } hbsc_dead_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        trip;
  } hbsc_oct_t;
endpackage
`default_nettype wire

// ---- core/hbsc_dead_time.sv ----
// non-overlapping high/low side drive of one channel
`timescale 1ns/1ps
`default_nettype none
module hbsc_dead_time (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       wantHigh,
  input  wire logic       wantLow,
  input  wire logic [7:0] deadCyc,
  output logic            hs,
  output logic            ls
);
  hbsc_pkg::hbsc_dead_t st, next_st;

  // both sides off, then dead time, then the new side
  always_comb begin
    next_st = st;
    if ((st.hs && !wantHigh) || (st.ls && !wantLow)) begin
      next_st.hs  = 1'b0;
      next_st.ls  = 1'b0;
      next_st.cnt = deadCyc;
    end else if (!st.hs && !st.ls) begin
      if (st.cnt != 8'h00) begin
        next_st.cnt = st.cnt - 8'h01;
      end else begin
        next_st.hs = wantHigh;
        next_st.ls = wantLow & ~wantHigh;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign hs = st.hs;
  assign ls = st.ls;

  property p_no_overlap;
    @(posedge clk) disable iff (rst) !(st.hs && st.ls);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both sides on");

  property p_gap;
    @(posedge clk) disable iff (rst) $fell(st.hs) |-> !st.ls;
  endproperty
  a_gap: assert property (p_gap) else $error("no dead time high to low");
endmodule // hbsc_dead_time
`default_nettype wire

// ---- core/hbsc_oc_timer.sv ----
// overcurrent delay filter of one channel
`timescale 1ns/1ps
`default_nettype none
module hbsc_oc_timer #(
  parameter logic [15:0] DELAY = 16'h00C8
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic oc,
  output logic      trip
);
  hbsc_pkg::hbsc_oct_t st, next_st;

  // trip only when overcurrent lasts past the delay
  always_comb begin
    next_st = st;
    if (!oc) begin
      next_st.cnt  = 16'h0000;
      next_st.trip = 1'b0;
    end else if (st.cnt == DELAY) begin
      next_st.trip = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign trip = st.trip;

  property p_trip_delay;
    @(posedge clk) disable iff (rst) st.trip |-> st.cnt == DELAY;
  endproperty
  a_trip_delay: assert property (p_trip_delay) else $error("trip before delay");
endmodule // hbsc_oc_timer
`default_nettype wire

// ---- core/hbsc_core.sv ----
// serial link, command word, fault status and drive decision of the half-bridge driver
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hbsc_regs.svh"

// How it works
// - underload then overcurrent on a channel reports code 10, then 01
// - overcurrent code 01 never steps straight to underload 10
// - valid frame is select high-low-high with 16 or more clocks, a whole multiple of 8
// - modulo-16 check for first 16 bits, modulo-8 after
// - good frame loads last 16 bits; bad frame is dropped whole
// - prefix bit is thermal flag ORed with serial input
// - prefix shows at select fall, status after first rising clock
// - power-on reset clears command and status, outputs high impedance
// - link and drive work only after reset and while enable is high
// - supply lockout turns drivers off, keeps data; overvoltage obeys lock bit
// - group bit picks which channels a command sets and reports
// - never both sides of a channel on; dead time on side change
// - driver stays on until commanded off or a fault
// - outputs 1,2 active on enable or pulse pin; config picks side
// - commands taken during lockout apply when lockout ends
// - supply faults recover by themselves; latched faults need reset
// - status reset bit clears latched faults of the selected group
// - status frozen during a frame, refreshed after it, not after reset bit
// - code 00 off, 01 overcurrent, 10 underload, 11 on
// - overcurrent past the delay latches channel off, code 01
module hbsc_core #(
  parameter logic [15:0] OC_DELAY_CYC = 16'(`HBSC_CYC_UP(`HBSC_OCD_NS))
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        selectN,
  input  wire logic        serialClock,
  input  wire logic        serialIn,
  output logic             serialOut,
  output logic             serialOutEn,
  input  wire logic        enablePin,
  input  wire logic [1:0]  extPulseInput,
  input  wire logic        supplyUndervoltage,
  input  wire logic        supplyOvervoltage,
  input  wire logic        overTemp,
  input  wire logic        thermalWarning,
  input  wire logic [7:0]  overcurrentDetect,
  input  wire logic [7:0]  underloadDetect,
  output logic [7:0]       highSideSwitch,
  output logic [7:0]       lowSideSwitch
);
  hbsc_pkg::hbsc_state_t st, next_st;
  hbsc_pkg::hbsc_pins_t  pinsRaw;
  logic [7:0]  ocTrip;
  logic [7:0]  drive;
  logic [7:0]  wantHigh;
  logic [7:0]  wantLow;
  logic [15:0] statWord;
  logic [15:0] codes;
  logic        grp;
  logic        selHigh;
  logic        sclkRise;
  logic        frameStart;
  logic        frameEnd;
  logic        frameOk;
  logic        lockout;
  logic        supFail;
  logic        srst;
  logic        apbDone;

  // **********************************************************
  // helpers
  // **********************************************************

  // priority encoding of one channel
  function automatic logic [1:0] codeOf(input logic o, input logic u, input logic d);
    if (o) return `HBSC_CODE_OVC;
    if (u) return `HBSC_CODE_UNDL;
    return d ? `HBSC_CODE_ON : `HBSC_CODE_OFF;
  endfunction

  function automatic logic inGroup(input int i, input logic g);
    return g ? (i >= `HBSC_GRP0_N) : (i < `HBSC_GRP0_N);
  endfunction

  function automatic int slotOf(input int i, input logic g);
    return g ? i - `HBSC_GRP0_N : i;
  endfunction

  // **********************************************************
  // pins, edges and drive decision
  // **********************************************************

  assign pinsRaw = '{sel: selectN, sclk: serialClock, sdi: serialIn, en: enablePin,
                     uv: supplyUndervoltage, ov: supplyOvervoltage, hot: overTemp,
                     warn: thermalWarning, pulse: extPulseInput,
                     oc: overcurrentDetect, ul: underloadDetect};

  // edges seen only on the second sync stage
  assign selHigh    = st.s2.sel;
  assign sclkRise   = st.s2.sclk & ~st.sclkD & ~selHigh;
  assign frameStart = st.selD & ~selHigh;
  assign frameEnd   = ~st.selD & selHigh;
  assign frameOk    = st.bitCnt == `HBSC_FRAME_MIN;
  assign grp        = st.cmdWord[`HBSC_CMD_GRP];
  assign srst       = st.inReg[`HBSC_CMD_SRST];
  assign supFail    = st.s2.uv | st.s2.ov;
  assign lockout    = st.s2.uv | (st.s2.ov & st.cmdWord[`HBSC_CMD_OVLK]);
  assign apbDone    = psel & penable & st.pready;

  // per-channel drive request
  always_comb begin
    logic act;
    logic blk;
    act = 1'b0;
    blk = 1'b0;
    for (int i = 0; i < 8; i++) begin
      act = st.cmd.en[i] | (i < `HBSC_PULSE_N && st.s2.pulse[i % 2]);
      // lockout only masks; command stays and resumes on recovery
      blk = ~st.live | st.thermal | st.ovc[i] | lockout
            | (st.undl[i] & st.cmdWord[`HBSC_CMD_ULOFF]);
      drive[i]    = act & ~blk;
      wantHigh[i] = drive[i] & st.cmd.cfg[i];
      wantLow[i]  = drive[i] & ~st.cmd.cfg[i];
    end
  end

  // status word of the selected group and all codes
  always_comb begin
    statWord = 16'h0000;
    codes    = 16'h0000;
    statWord[`HBSC_ST_OVC]  = |st.ovc;
    statWord[`HBSC_ST_SUPF] = supFail;
    statWord[`HBSC_ST_UNDL] = |st.undl;
    statWord[`HBSC_ST_WARN] = st.s2.warn;
    for (int i = 0; i < 8; i++) begin
      codes[2*i +: 2] = codeOf(st.ovc[i], st.undl[i], drive[i]);
      if (inGroup(i, grp)) begin
        statWord[2*slotOf(i, grp)+1 +: 2] = codes[2*i +: 2];
      end
    end
  end

  // **********************************************************
  // next state
  // **********************************************************

  always_comb begin
    next_st       = st;
    next_st.s1    = pinsRaw;
    next_st.s2    = st.s1;
    next_st.sclkD = st.s2.sclk;
    next_st.selD  = st.s2.sel;
    next_st.live  = st.s2.en;

    // frame start: counters cleared, frozen status taken
    if (frameStart) begin
      next_st.bitCnt   = 5'h00;
      next_st.started  = 1'b0;
      next_st.outReg   = st.snap;
      next_st.snapHold = 1'b0;
    end

    // rising link clock: shift in, count, shift out
    if (sclkRise && st.live) begin
      next_st.started = 1'b1;
      next_st.inReg   = {st.inReg[14:0], st.s2.sdi};
      next_st.bitCnt  = (st.bitCnt == `HBSC_FRAME_WRAP) ? `HBSC_FRAME_MIN
                                                        : st.bitCnt + 5'h01;
      if (st.started) begin
        next_st.outReg = {st.outReg[14:0], st.inReg[0]};
      end
    end

    // serial output: prefix before first clock, then status
    next_st.serialOut   = 1'b0;
    if (!selHigh) begin
      next_st.serialOut = next_st.started ? next_st.outReg[15]
                                          : (st.thermal | st.s2.sdi);
    end
    next_st.serialOutEn = ~selHigh & st.live;

    // status refresh only between frames
    if (selHigh && !st.snapHold) begin
      next_st.snap = statWord;
    end

    // frame end: take or drop the command
    if (frameEnd && st.live) begin
      next_st.frameErr = ~frameOk;
      if (frameOk) begin
        next_st.cmdWord = st.inReg;
        for (int i = 0; i < 8; i++) begin
          if (inGroup(i, st.inReg[`HBSC_CMD_GRP])) begin
            next_st.cmd.en[i]  = st.inReg[`HBSC_CMD_EN + slotOf(i, st.inReg[`HBSC_CMD_GRP])];
            next_st.cmd.cfg[i] = st.inReg[`HBSC_CMD_CFG + slotOf(i, st.inReg[`HBSC_CMD_GRP])];
            if (srst) begin
              next_st.ovc[i]  = 1'b0;
              next_st.undl[i] = 1'b0;
            end
          end
        end
        if (srst) begin
          next_st.thermal  = 1'b0;
          next_st.snapHold = 1'b1;
        end
      end
    end

    // fault latching after the clear, so a set wins
    for (int i = 0; i < 8; i++) begin
      if (ocTrip[i] && drive[i]) begin
        next_st.ovc[i] = 1'b1;
      end
      if (st.s2.ul[i] && drive[i]) begin
        next_st.undl[i] = 1'b1;
      end
    end
    if (st.s2.hot) begin
      next_st.thermal = 1'b1;
    end

    // apb: answer one cycle into the access phase
    next_st.pready = psel & penable & ~st.pready;
    if (psel && penable && !st.pready) begin
      next_st.prdata  = 32'h0000_0000;
      next_st.pslverr = 1'b0;
      unique case (paddr)
        `HBSC_OFS_CTRL: next_st.prdata = {24'h00_0000, st.dead};
        `HBSC_OFS_CMD:  next_st.prdata = {16'h0000, st.cmdWord};
        `HBSC_OFS_STAT: next_st.prdata = {13'h0000, st.frameErr, supFail, st.thermal,
                                          st.undl, st.ovc};
        `HBSC_OFS_CODE: next_st.prdata = {16'h0000, codes};
        default:        next_st.pslverr = 1'b1;
      endcase
    end
    if (apbDone && pwrite && paddr == `HBSC_OFS_CTRL) begin
      next_st.dead = pwdata[7:0];
    end

    // enable low: command and status except frame error back to reset values
    if (!st.s2.en) begin
      next_st.cmdWord     = `HBSC_RST_CMD;
      next_st.cmd         = '0;
      next_st.ovc         = 8'h00;
      next_st.undl        = 8'h00;
      next_st.thermal     = 1'b0;
      next_st.snap        = 16'h0000;
      next_st.serialOut   = 1'b0;
      next_st.serialOutEn = 1'b0;
    end
  end

  // state register; reset clears command and status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st      <= '0;
      st.dead <= 8'(`HBSC_CYC_UP(`HBSC_DEAD_NS));
    end else if (ce) begin
      st <= next_st;
    end
  end

  // **********************************************************
  // channels
  // **********************************************************

  for (genvar g = 0; g < 8; g++) begin : gChan
    hbsc_oc_timer #(
      .DELAY (OC_DELAY_CYC)
    ) uOcTimer (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .oc   (st.s2.oc[g]),
      .trip (ocTrip[g])
    );
    hbsc_dead_time uDead (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .wantHigh (wantHigh[g]),
      .wantLow  (wantLow[g]),
      .deadCyc  (st.dead),
      .hs       (highSideSwitch[g]),
      .ls       (lowSideSwitch[g])
    );
  end

  assign serialOut   = st.serialOut;
  assign serialOutEn = st.serialOutEn;
  assign prdata      = st.prdata;
  assign pready      = st.pready;
  assign pslverr     = st.pslverr;

  // **********************************************************
  // checks
  // **********************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_good_end;
    ce && frameEnd && frameOk && st.live;
  endsequence
  sequence s_bad_end;
    ce && frameEnd && !frameOk && st.live;
  endsequence

  property p_accept;
    s_good_end |=> st.cmdWord == $past(st.inReg);
  endproperty
  a_accept: assert property (p_accept) else $error("good frame not taken");

  property p_reject;
    s_bad_end |=> $stable(st.cmdWord) && st.frameErr;
  endproperty
  a_reject: assert property (p_reject) else $error("bad frame changed command");

  property p_wrap;
    ce && sclkRise && st.live && st.bitCnt == `HBSC_FRAME_WRAP |=> st.bitCnt == `HBSC_FRAME_MIN;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap to 16");

  property p_ovc_code;
    st.ovc[0] |-> codes[1:0] == `HBSC_CODE_OVC;
  endproperty
  a_ovc_code: assert property (p_ovc_code) else $error("overcurrent code not 01");

  property p_no_ovc_to_undl;
    codes[1:0] == `HBSC_CODE_OVC ##1 codes[1:0] != `HBSC_CODE_OVC
      |-> codes[1:0] != `HBSC_CODE_UNDL;
  endproperty
  a_no_ovc_to_undl: assert property (p_no_ovc_to_undl) else $error("01 went to 10");

  property p_prefix;
    ce && !selHigh && (frameStart || !st.started) && !sclkRise && st.live && st.s2.en
      |=> st.serialOut == $past(st.thermal | st.s2.sdi);
  endproperty
  a_prefix: assert property (p_prefix) else $error("prefix bit wrong");

  property p_out_idle;
    ce && selHigh |=> !st.serialOutEn && !st.serialOut;
  endproperty
  a_out_idle: assert property (p_out_idle) else $error("serial out driven when idle");

  property p_freeze;
    ce && !selHigh && !st.selD |=> $stable(st.snap);
  endproperty
  a_freeze: assert property (p_freeze) else $error("status moved in a frame");

  property p_lockout;
    ce && $past(ce) && $past(st.s2.uv)
      |-> (highSideSwitch == 8'h00) && (lowSideSwitch == 8'h00);
  endproperty
  a_lockout: assert property (p_lockout) else $error("drive on during undervoltage");
endmodule // hbsc_core
`default_nettype wire

// ---- tb/hbsc_host_model.sv ----
// host side of the serial link: frames, bit timing and status capture
`timescale 1ns/1ps
`default_nettype none
module hbsc_host_model (
  input  wire logic clk,
  output logic      selectN,
  output logic      serialClock,
  output logic      serialIn,
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  // ********
  // frame engine
  // ********
  // idle: select high, clock and data low
  initial begin
    selectN = 1'b1;
    serialClock = 1'b0;
    serialIn = 1'b0;
  end

  // wait whole system clocks
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one frame, msb first, 400 ns link period; pre is enable and prefix
  task automatic xfer(input int nb, input logic [31:0] tx,
                      output logic [31:0] rx, output logic [1:0] pre);
    rx = '0;
    selectN <= 1'b0;
    hold(4);
    pre = {serialOutEn, serialOut};
    for (int i = nb - 1; i >= 0; i--) begin
      serialIn <= tx[i];
      hold(4);
      serialClock <= 1'b1;
      hold(4);
      rx = {rx[30:0], serialOutEn ? serialOut : ~rx[0]};
      serialClock <= 1'b0;
    end
    serialIn <= 1'b0;
    hold(4);
    selectN <= 1'b1;
    hold(8);
  endtask
endmodule // hbsc_host_model
`default_nettype wire

// ---- tb/hbsc_core_tb.sv ----
// self-checking bench of the half-bridge serial control core
`timescale 1ns/1ps
`default_nettype none
module hbsc_core_tb;
  // ********
  // stimulus and checks
  // ********
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        selectN;
  logic        serialClock;
  logic        serialIn;
  logic        serialOut;
  logic        serialOutEn;
  logic        enablePin = 1'b1;
  logic [1:0]  extPulse = 2'h0;
  logic        underV = 1'b0;
  logic        overV = 1'b0;
  logic        overTemp = 1'b0;
  logic        warnIn = 1'b0;
  logic [7:0]  ocDet = 8'h00;
  logic [7:0]  ulDet = 8'h00;
  logic [7:0]  hsw;
  logic [7:0]  lsw;
  logic [31:0] rdata;
  logic [31:0] rx;
  logic [1:0]  pre;
  logic        err;
  int          fails = 0;
  int          checksDone = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  // design with a short overcurrent delay
  hbsc_core #(.OC_DELAY_CYC(16'h0004)) uut (
    .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .selectN(selectN),
    .serialClock(serialClock), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .enablePin(enablePin), .extPulseInput(extPulse),
    .supplyUndervoltage(underV), .supplyOvervoltage(overV), .overTemp(overTemp),
    .thermalWarning(warnIn), .overcurrentDetect(ocDet), .underloadDetect(ulDet),
    .highSideSwitch(hsw), .lowSideSwitch(lsw)
  );

  // far side host
  hbsc_host_model host (
    .clk(clk), .selectN(selectN), .serialClock(serialClock),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn)
  );

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("wrong value at %0t: no bus answer", $time);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic frm(input int nb, input logic [31:0] tx);
    host.xfer(nb, tx, rx, pre);
    w(20);
  endtask

  // high sides above low sides
  task automatic drv(input logic [15:0] e);
    chk({16'h0, hsw, lsw}, {16'h0, e});
  endtask

  // both sides of a channel never on together
  always @(posedge clk) if ((hsw & lsw) !== 8'h00) chk({24'h0, hsw & lsw}, 32'h0);

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // cut a hang short
  initial begin
    w(60000);
    fails++;
    $display("wrong value at %0t: watchdog", $time);
    close_out();
  end

  // test sequence
  initial begin
    w(3);
    chk({15'h0, serialOutEn, hsw, lsw}, 32'h0);
    w(1);
    rst <= 1'b0;
    w(6);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h00, 32'hA);
    rd(8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h00, 32'h4);
    rd(8'h00, 32'h4);
    apb(1'b1, 8'h04, 32'hFFFF);
    rd(8'h04, 32'h0);
    $display("register test over");
    frm(16, 32'h0082);
    rd(8'h04, 32'h82);
    drv(16'h0100);
    rd(8'h0C, 32'h3);
    frm(12, 32'hFFF);
    rd(8'h04, 32'h82);
    rd(8'h08, 32'h40000);
    frm(24, 32'hA50084);
    rd(8'h04, 32'h84);
    drv(16'h0001);
    rd(8'h08, 32'h0);
    frm(20, 32'h00081);
    rd(8'h04, 32'h84);
    $display("frame test over");
    frm(16, 32'h0002);
    drv(16'h0000);
    extPulse <= 2'b01;
    w(20);
    drv(16'h0100);
    extPulse <= 2'b10;
    w(20);
    drv(16'h0002);
    extPulse <= 2'b00;
    w(20);
    drv(16'h0000);
    $display("pulse test over");
    frm(16, 32'h0082);
    ulDet <= 8'h01;
    w(10);
    rd(8'h0C, 32'h2);
    ocDet <= 8'h01;
    w(20);
    rd(8'h0C, 32'h1);
    drv(16'h0000);
    rd(8'h08, 32'h101);
    ocDet <= 8'h00;
    ulDet <= 8'h00;
    frm(16, 32'h0083);
    chk({31'h0, rx[15]}, 32'h1);
    rd(8'h0C, 32'h3);
    drv(16'h0100);
    ocDet <= 8'h01;
    w(20);
    ocDet <= 8'h00;
    ulDet <= 8'h01;
    w(20);
    rd(8'h0C, 32'h1);
    ulDet <= 8'h00;
    frm(16, 32'h0083);
    rd(8'h0C, 32'h3);
    $display("fault test over");
    overTemp <= 1'b1;
    w(10);
    overTemp <= 1'b0;
    warnIn <= 1'b1;
    frm(16, 32'h0082);
    chk({30'h0, pre}, 32'h3);
    rd(8'h08, 32'h10000);
    frm(16, 32'h0083);
    chk({30'h0, pre}, 32'h3);
    frm(16, 32'h0082);
    chk({30'h0, pre}, 32'h2);
    warnIn <= 1'b0;
    $display("prefix test over");
    underV <= 1'b1;
    w(10);
    drv(16'h0000);
    rd(8'h04, 32'h82);
    rd(8'h08, 32'h20000);
    frm(16, 32'h0084);
    drv(16'h0000);
    underV <= 1'b0;
    w(20);
    drv(16'h0001);
    rd(8'h08, 32'h0);
    overV <= 1'b1;
    w(20);
    drv(16'h0001);
    overV <= 1'b0;
    frm(16, 32'h8084);
    overV <= 1'b1;
    w(20);
    drv(16'h0000);
    overV <= 1'b0;
    w(20);
    drv(16'h0001);
    $display("supply test over");
    enablePin <= 1'b0;
    w(6);
    rd(8'h04, 32'h0);
    drv(16'h0000);
    frm(16, 32'h0082);
    rd(8'h04, 32'h0);
    enablePin <= 1'b1;
    w(6);
    frm(16, 32'h0082);
    rd(8'h04, 32'h82);
    $display("enable test over");
    close_out();
  end
endmodule // hbsc_core_tb
`default_nettype wire
